// ---- verilog/mpwm_map.svh ----
// Purpose: register offsets, field positions and reset values of the PWM timer
// Assumes: word-indexed register port, 8-bit data per register
// Notes:   definitions only
`ifndef MPWM_MAP_SVH
`define MPWM_MAP_SVH

`define MPWM_ADDR_W        6
`define MPWM_DATA_W        8
// ----------------------------------------
// Control registers
// ----------------------------------------
`define MPWM_OFS_ENABLE    6'h00
`define MPWM_OFS_POLARITY  6'h01
`define MPWM_OFS_CLKSEL    6'h02
`define MPWM_OFS_PRESCALE  6'h03
`define MPWM_OFS_CENTER    6'h04
`define MPWM_OFS_JOIN      6'h05
`define MPWM_OFS_SCALE_A   6'h06
`define MPWM_OFS_SCALE_B   6'h07
`define MPWM_OFS_OUTPUT    6'h08
// ----------------------------------------
// Per-channel banks, channel n at base + n
// ----------------------------------------
`define MPWM_OFS_COUNT     6'h10
`define MPWM_OFS_PERIOD    6'h18
`define MPWM_OFS_DUTY      6'h20
// Field layout of the prescale register
`define MPWM_PRE_A_LSB     0
`define MPWM_PRE_B_LSB     4
// Reset values
`define MPWM_RST_PERIOD    8'hff
`define MPWM_RST_DUTY      8'h00
`define MPWM_RST_SCALE     8'h00
`define MPWM_RST_POLARITY  8'hff

`endif

// ---- verilog/mpwm_pkg.sv ----
// Purpose: shared types of the PWM timer
// Assumes: mpwm_map.svh holds every number
// Notes:   types only
package mpwm_pkg;
    typedef logic [3:0] mpwm_ticks_t;     // a, b, scaled a, scaled b
    typedef struct packed
    {
        logic        tick;       // Counter advance
        logic        enable;     // Channel running
        logic        center;     // Up/down counting
        logic        polarity;   // 1: high during duty
        logic [15:0] period;     // Shadowed period
        logic [15:0] duty;       // Shadowed duty
    } mpwm_chan_cfg_t;
endpackage

// ---- verilog/mpwm_clock_gen.sv ----
// Purpose: four counter tick sources, two prescaled and two further scaled
// Assumes: single clock, no clock enable, ticks are one-cycle pulses
// Notes:   scale value 0 means divide by 256
`timescale 1ns/1ps
`include "mpwm_map.svh"
module mpwm_clock_gen
    import mpwm_pkg::*;
(
    input  wire logic        clk,        // System clock
    input  wire logic        reset_n,    // Async reset, active low
    input  wire logic [7:0]  prescale,   // Two 3-bit power-of-two selects
    input  wire logic [7:0]  scale_a,    // First scale divisor
    input  wire logic [7:0]  scale_b,    // Second scale divisor
    output mpwm_ticks_t      ticks       // One-cycle tick pulses
);
    logic [7:0] pre_cnt;
    logic [7:0] sa_cnt;
    logic [7:0] sb_cnt;
    logic [7:0] pre_prev;
    logic       tick_a;
    logic       tick_b;
    logic       sa_hit;
    logic       sb_hit;
    logic       scaled_clock_first;
    logic       scaled_clock_second;
    logic [2:0] sel_a;
    logic [2:0] sel_b;

    assign sel_a = prescale[`MPWM_PRE_A_LSB +: 3];
    assign sel_b = prescale[`MPWM_PRE_B_LSB +: 3];

    // ----------------------------------------
    // Free-running prescaler
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pre_cnt  <= 8'h00;
            pre_prev <= 8'h00;
        end
        else
        begin
            pre_cnt  <= pre_cnt + 8'h01;
            pre_prev <= pre_cnt;
        end
    end

    // Tick on a rising bit of the chosen stage; select 0 ticks every cycle
    always_comb
    begin
        tick_a = (sel_a == 3'h0) ? 1'b1
               : (pre_cnt[sel_a - 3'h1] & ~pre_prev[sel_a - 3'h1]);
        tick_b = (sel_b == 3'h0) ? 1'b1
               : (pre_cnt[sel_b - 3'h1] & ~pre_prev[sel_b - 3'h1]);
    end

    assign sa_hit = tick_a && (sa_cnt == scale_a - 8'h01);
    assign sb_hit = tick_b && (sb_cnt == scale_b - 8'h01);

    // ----------------------------------------
    // Scaled sources
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            sa_cnt              <= 8'h00;
            sb_cnt              <= 8'h00;
            scaled_clock_first  <= 1'b0;
            scaled_clock_second <= 1'b0;
        end
        else
        begin
            scaled_clock_first  <= sa_hit;
            scaled_clock_second <= sb_hit;
            if (tick_a)
                sa_cnt <= sa_hit ? 8'h00 : sa_cnt + 8'h01;
            if (tick_b)
                sb_cnt <= sb_hit ? 8'h00 : sb_cnt + 8'h01;
        end
    end

    assign ticks = {scaled_clock_second, scaled_clock_first, tick_b, tick_a};
endmodule

// ---- verilog/mpwm_channel.sv ----
// Purpose: one counter and comparator, 8 or 16 bits wide
// Assumes: period and duty arrive already shadowed
// Notes:   counter returns to zero on disable
`timescale 1ns/1ps
`include "mpwm_map.svh"
module mpwm_channel
    import mpwm_pkg::*;
(
    input  wire logic           clk,       // System clock
    input  wire logic           reset_n,   // Async reset, active low
    input  mpwm_chan_cfg_t      cfg,       // Tick, mode and limits
    output logic [15:0]         count,     // Counter value
    output logic                at_end,    // Period end pulse
    output logic                wave       // Pin level
);
    logic down;
    logic last;
    logic active;

    // End of period: left at period-1, centre on return to zero going down
    // Centre mode shows the top value twice, so a period is exactly two ramps
    assign last   = cfg.center ? (down && count == 16'h0000)
                               : (count + 16'h0001 >= cfg.period);
    assign at_end = cfg.tick && cfg.enable && last;

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count <= 16'h0000;
            down  <= 1'b0;
        end
        else if (!cfg.enable)
        begin
            count <= 16'h0000;
            down  <= 1'b0;
        end
        else if (cfg.tick)
        begin
            if (!cfg.center)
                count <= last ? 16'h0000 : count + 16'h0001;
            else if (!down)
            begin
                if (count + 16'h0001 >= cfg.period)
                    down <= 1'b1;    // Turn at period-1
                else
                    count <= count + 16'h0001;
            end
            else if (last)
            begin
                count <= 16'h0000;
                down  <= 1'b0;
            end
            else
                count <= count - 16'h0001;
        end
    end

    // Duty 0 never active, duty >= period always active
    assign active = cfg.enable && (count < cfg.duty);

    // Registered pin level; inactive level follows polarity
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            wave <= 1'b0;
        else
            wave <= active ? cfg.polarity : ~cfg.polarity;
    end
endmodule

// ---- verilog/mpwm_top.sv ----
// Purpose: eight-channel pulse-width modulation timer
// Assumes: register port, 8-bit data, read data one cycle after strobe
// Notes:
// Contract
// - eight channels, each with 8-bit period and duty by default.
// - every channel has its own counter, period and duty.
// - duty ranges from always inactive at 0% to always active at 100%.
// - software picks each channel's output polarity.
// - each channel counts left aligned or up/down centre aligned.
// - pairs 7/6, 5/4, 3/2, 1/0 may join into 16-bit channels.
// - joining is per pair, so any mix from 8/0 to 0/4 works.
// - period and duty load from buffers at period end or when disabled.
// - four counter clock sources: two prescaled, two further scaled.
// - each channel is enabled separately; a disabled counter stands still. Here a disabled counter is cleared to zero and held there.
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/1ps
`include "mpwm_map.svh"
module mpwm_top
    import mpwm_pkg::*;
(
    input  wire logic                    clk,       // System clock, 200 MHz
    input  wire logic                    reset_n,   // Async reset, active low
    input  wire logic [`MPWM_ADDR_W-1:0] addr,      // Register index
    input  wire logic [`MPWM_DATA_W-1:0] wdata,     // Write data
    input  wire logic                    wr,        // Write strobe
    input  wire logic                    rd,        // Read strobe
    output logic [`MPWM_DATA_W-1:0]      rdata,     // Read data, next cycle
    output logic [7:0]                   pwm_out    // Output pins
);
    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0]     enable;
    logic [7:0]     polarity;
    logic [7:0]     clksel;
    logic [7:0]     prescale;
    logic [7:0]     center;
    logic [3:0]     join_pair;
    logic [7:0]     scale_a;
    logic [7:0]     scale_b;

    // Software-side buffers; the counters never see these directly
    logic [7:0]     per_buf [8];
    logic [7:0]     duty_buf [8];

    // Values in force for the running period
    logic [7:0]     per_act [8];
    logic [7:0]     duty_act [8];

    // Counter tick sources
    mpwm_ticks_t    ticks;

    // Channel results
    logic [15:0]    ch_count [8];
    logic [7:0]     ch_end;
    logic [7:0]     ch_wave;
    logic [7:0]     wave_out;

    // Per-channel setup and reload strobes
    mpwm_chan_cfg_t cfg [8];
    logic [7:0]     load;

    // Read path
    logic [7:0]     next_rdata;

    // ----------------------------------------
    // Control register writes
    // ----------------------------------------
    // Mode bits that shape the waveforms
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            enable    <= 8'h00;
            polarity  <= `MPWM_RST_POLARITY;
            center    <= 8'h00;
            join_pair <= 4'h0;
        end
        else if (wr)
        begin
            unique case (addr)
                `MPWM_OFS_ENABLE:   enable    <= wdata;
                `MPWM_OFS_POLARITY: polarity  <= wdata;
                `MPWM_OFS_CENTER:   center    <= wdata;
                `MPWM_OFS_JOIN:     join_pair <= wdata[3:0];
                default:            ;
            endcase
        end
    end

    // Clock source selection, kept apart from the mode bits
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            clksel   <= 8'h00;
            prescale <= 8'h00;
            scale_a  <= `MPWM_RST_SCALE;
            scale_b  <= `MPWM_RST_SCALE;
        end
        else if (wr)
        begin
            unique case (addr)
                `MPWM_OFS_CLKSEL:   clksel   <= wdata;
                `MPWM_OFS_PRESCALE: prescale <= wdata;
                `MPWM_OFS_SCALE_A:  scale_a  <= wdata;
                `MPWM_OFS_SCALE_B:  scale_b  <= wdata;
                default:            ;
            endcase
        end
    end

    // ----------------------------------------
    // Clock sources
    // ----------------------------------------
    mpwm_clock_gen u_clock_gen
    (
        .clk      (clk),
        .reset_n  (reset_n),
        .prescale (prescale),
        .scale_a  (scale_a),
        .scale_b  (scale_b),
        .ticks    (ticks)
    );

    // ----------------------------------------
    // Channel slices
    // ----------------------------------------
    // Odd channel of a joined pair owns the pair; its controls rule both halves, except the low pin's rest level, which follows the low channel's polarity.
    // The low channel's period/duty byte is the high byte of the 16-bit pair.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_ch
            localparam int PAIR = gi / 2;
            localparam int LO   = gi & 6;
            localparam int HI   = LO + 1;
            logic joined;
            logic use_a;
            logic my_end;

            assign joined = join_pair[PAIR];
            assign use_a  = (gi % 4) < 2;   // Channels 0,1,4,5 use A; 2,3,6,7 B

            // Buffered period
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    per_buf[gi] <= `MPWM_RST_PERIOD;
                else if (wr && addr == `MPWM_OFS_PERIOD + 6'(gi))
                    per_buf[gi] <= wdata;
            end

            // Buffered duty; software may rewrite it at any time
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    duty_buf[gi] <= `MPWM_RST_DUTY;
                else if (wr && addr == `MPWM_OFS_DUTY + 6'(gi))
                    duty_buf[gi] <= wdata;
            end

            // Joined halves reload together at the pair's period end
            assign my_end   = joined ? ch_end[HI] : ch_end[gi];
            assign load[gi] = my_end || !(joined ? enable[HI] : enable[gi]);

            // Period in force; a mid-period reload would tear the waveform
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    per_act[gi] <= `MPWM_RST_PERIOD;
                else if (load[gi])
                    per_act[gi] <= per_buf[gi];
            end

            // Duty in force, reloaded with the period
            always_ff @(posedge clk or negedge reset_n)
            begin
                if (!reset_n)
                    duty_act[gi] <= `MPWM_RST_DUTY;
                else if (load[gi])
                    duty_act[gi] <= duty_buf[gi];
            end

            // Channel setup; a joined low half is held idle
            always_comb
            begin
                if (use_a)
                    cfg[gi].tick = clksel[gi] ? ticks[2] : ticks[0];
                else
                    cfg[gi].tick = clksel[gi] ? ticks[3] : ticks[1];
                cfg[gi].enable   = enable[gi] && !(joined && gi == LO);
                cfg[gi].center   = center[gi];
                cfg[gi].polarity = polarity[gi];
                if (joined && gi == HI)
                begin
                    cfg[gi].period = {per_act[LO], per_act[HI]};
                    cfg[gi].duty   = {duty_act[LO], duty_act[HI]};
                end
                else
                begin
                    cfg[gi].period = {8'h00, per_act[gi]};
                    cfg[gi].duty   = {8'h00, duty_act[gi]};
                end
            end

            mpwm_channel u_channel
            (
                .clk     (clk),
                .reset_n (reset_n),
                .cfg     (cfg[gi]),
                .count   (ch_count[gi]),
                .at_end  (ch_end[gi]),
                .wave    (ch_wave[gi])
            );

            // Joined low pin rests inactive; the pair's wave leaves on the odd pin
            assign wave_out[gi] = (joined && gi == LO) ? ~polarity[gi] : ch_wave[gi];
        end
    endgenerate

    // Output pins from flip-flops. The pins trail the compare by two
    // cycles, one in the channel and one here; pin readback sees that lag.
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            pwm_out <= 8'h00;
        else
            pwm_out <= wave_out;
    end

    // ----------------------------------------
    // Read mux; unmapped indices read zero
    // ----------------------------------------
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (addr)
            `MPWM_OFS_ENABLE:   next_rdata = enable;
            `MPWM_OFS_POLARITY: next_rdata = polarity;
            `MPWM_OFS_CLKSEL:   next_rdata = clksel;
            `MPWM_OFS_PRESCALE: next_rdata = prescale;
            `MPWM_OFS_CENTER:   next_rdata = center;
            `MPWM_OFS_JOIN:     next_rdata = {4'h0, join_pair};
            `MPWM_OFS_SCALE_A:  next_rdata = scale_a;
            `MPWM_OFS_SCALE_B:  next_rdata = scale_b;
            `MPWM_OFS_OUTPUT:   next_rdata = pwm_out;
            default:
            begin
                for (int i = 0; i < 8; i++)
                begin
                    // A joined pair's even index shows the high count byte
                    if (addr == `MPWM_OFS_COUNT + 6'(i))
                    begin
                        if (join_pair[i/2] && (i % 2 == 0))
                            next_rdata = ch_count[i | 1][15:8];
                        else
                            next_rdata = ch_count[i][7:0];
                    end
                    if (addr == `MPWM_OFS_PERIOD + 6'(i))
                        next_rdata = per_buf[i];
                    if (addr == `MPWM_OFS_DUTY + 6'(i))
                        next_rdata = duty_buf[i];
                end
            end
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            rdata <= 8'h00;
        else
            rdata <= rd ? next_rdata : 8'h00;
    end
endmodule

// ---- testbench/mpwm_checker.sv ----
// Purpose: port assertions for the pulse-width timer
// Assumes: pins settle two cycles after a mode write
// Notes:   mode bits are shadowed from observed writes
`timescale 1ns/1ps
`include "mpwm_map.svh"
module mpwm_checker
(
    input wire logic       clk,     // System clock
    input wire logic       reset_n, // Reset, active low
    input wire logic [5:0] addr,    // Register index
    input wire logic [7:0] wdata,   // Write data
    input wire logic       wr,      // Write strobe
    input wire logic       rd,      // Read strobe
    input wire logic [7:0] rdata,   // Read data
    input wire logic [7:0] pwm_out  // Pins
);
    // ----
    // Shadows
    // ----
    logic [7:0] en;    // Enables
    logic [7:0] pol;   // Polarities
    logic [3:0] jn;    // Joined pairs
    logic [2:0] quiet; // Age of last mode write
    logic [7:0] rest;  // Pins bound to idle
    logic       mode;  // Write that moves pins
    // Joined even pins never drive, so they idle too
    assign rest = ~en | {1'b0, jn[3], 1'b0, jn[2], 1'b0, jn[1], 1'b0, jn[0]};
    assign mode = wr && addr inside {`MPWM_OFS_ENABLE, `MPWM_OFS_POLARITY, `MPWM_OFS_JOIN};
    // Mode shadows follow writes
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            en  <= 8'h00;
            pol <= `MPWM_RST_POLARITY;
            jn  <= 4'h0;
        end
        else if (mode)
        begin
            en  <= (addr == `MPWM_OFS_ENABLE) ? wdata : en;
            pol <= (addr == `MPWM_OFS_POLARITY) ? wdata : pol;
            jn  <= (addr == `MPWM_OFS_JOIN) ? wdata[3:0] : jn;
        end
    end
    // Saturates at 7, well past the two-stage pin lag
    always_ff @(posedge clk or negedge reset_n)
    begin
        if (!reset_n)
            quiet <= 3'h0;
        else
            quiet <= mode ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
    end
    // ----
    // Properties
    // ----
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    property p_rdata_idle;
        !rd |=> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("stray read data");
    property p_ctrl_back;
        wr && addr inside {[`MPWM_OFS_ENABLE:`MPWM_OFS_CLKSEL], `MPWM_OFS_CENTER}
            ##1 rd && $stable(addr) |=> rdata == $past(wdata, 2);
    endproperty
    a_ctrl_back: assert property (p_ctrl_back) else $error("control readback");
    property p_buf_back;
        wr && addr inside {[`MPWM_OFS_PERIOD:`MPWM_OFS_DUTY + 6'h07]}
            ##1 rd && $stable(addr) |=> rdata == $past(wdata, 2);
    endproperty
    a_buf_back: assert property (p_buf_back) else $error("buffer readback");
    property p_join_back;
        wr && addr == `MPWM_OFS_JOIN ##1 rd && $stable(addr)
            |=> ((rdata ^ $past(wdata, 2)) & 8'h0f) == 8'h00;
    endproperty
    a_join_back: assert property (p_join_back) else $error("join readback");
    property p_unmapped;
        rd && !(addr inside {[6'h00:`MPWM_OFS_OUTPUT], [`MPWM_OFS_COUNT:6'h27]})
            |=> rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read");
    property p_rest;
        quiet == 3'h7 |-> ((pwm_out ^ ~pol) & rest) == 8'h00;
    endproperty
    a_rest: assert property (p_rest) else $error("idle pin level");
    property p_idle_count;
        rd && quiet == 3'h7 && addr inside {[`MPWM_OFS_COUNT:`MPWM_OFS_COUNT + 6'h07]}
            && !en[addr[2:0]] && !en[addr[2:0] ^ 3'h1] |=> rdata == 8'h00;
    endproperty
    a_idle_count: assert property (p_idle_count) else $error("idle counter moved");
    property p_out_read;
        rd && addr == `MPWM_OFS_OUTPUT && quiet == 3'h7 && rest == 8'hff |=> rdata == ~pol;
    endproperty
    a_out_read: assert property (p_out_read) else $error("pin readback");
    c_ctrl_back: cover property (wr && addr == `MPWM_OFS_ENABLE ##1 rd);
    c_join_all: cover property (wr && addr == `MPWM_OFS_JOIN && wdata[3:0] == 4'hf);
    c_rest_read: cover property (rd && addr == `MPWM_OFS_OUTPUT && rest == 8'hff);
endmodule
bind mpwm_top mpwm_checker u_chk (.clk(clk), .reset_n(reset_n), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .pwm_out(pwm_out));

// ---- testbench/mpwm_load_model.sv ----
// Purpose: loads on the pulse pins, tallying high cycles and rises
// Assumes: pins sampled on the system clock
// Notes:   a clear edge counts nothing, so windows are exact
`timescale 1ns/1ps
module mpwm_load_model
(
    input  wire logic             clk,    // System clock
    input  wire logic             clear,  // Restart tallies
    input  wire logic [7:0]       pins,   // Pulse pins
    output logic      [7:0][15:0] hi_cnt, // High cycles
    output logic      [7:0][15:0] rises   // Rising edges
);
    logic [7:0] last; // Levels one cycle back
    // Tally per pin
    always_ff @(posedge clk)
    begin
        last <= pins;
        for (int n = 0; n < 8; n++)
        begin
            hi_cnt[n] <= clear ? 16'h0 : hi_cnt[n] + 16'(pins[n]);
            rises[n]  <= clear ? 16'h0 : rises[n] + 16'(pins[n] & ~last[n]);
        end
    end
endmodule

// ---- testbench/multichannel_pulse_width_modulator_test.sv ----
// Purpose: self-checking bench for the pulse-width timer
// Assumes: period 8, prescale 0 ticks every clock
// Notes:   duty judged by high cycles over whole periods
`timescale 1ns/1ps
`include "mpwm_map.svh"
module multichannel_pulse_width_modulator_test;
    logic             clk;         // System clock
    logic             reset_n;     // Reset, active low
    logic [5:0]       addr;        // Register index
    logic [7:0]       wdata;       // Write data
    logic             wr;          // Write strobe
    logic             rd;          // Read strobe
    logic [7:0]       rdata;       // Read data
    logic [7:0]       pwm_out;     // Pins
    logic             clr;         // Tally restart
    logic [7:0][15:0] hi_cnt;      // High cycles
    logic [7:0][15:0] rises;       // Rising edges
    logic [3:0]       j;           // Join pattern
    int               n_errors;    // Mismatches
    int               check_count; // Comparisons
    mpwm_top dut (.clk(clk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pwm_out(pwm_out));
    mpwm_load_model load (.clk(clk), .clear(clr), .pins(pwm_out), .hi_cnt(hi_cnt),
        .rises(rises));
    // Free-running clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // ----
    // Tasks
    // ----
    task automatic conclude();
        if (n_errors == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask
    // Strobe drops at the edge, so the next access may follow at once
    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check({8'h00, rdata}, {8'h00, exp});
    endtask
    task automatic measure(input int n);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [7:0] duty(input int n);
        return (n == 7) ? 8'h08 : 8'(n);
    endfunction
    // Joined pair: even byte is high, period is 8
    function automatic logic [15:0] exp_hi(input logic [3:0] jp, input int n, input int win);
        logic [15:0] d16;
        d16 = jp[n / 2] ? {duty(n - 1), duty(n)} : {8'h00, duty(n)};
        if (jp[n / 2] && n % 2 == 0)
            return 16'h0;
        return (d16 >= 16'h8) ? 16'(win) : 16'(win / 8) * d16;
    endfunction
    task automatic sweep(input logic [3:0] jp, input logic [7:0] pl, input int win);
        repeat (40) @(posedge clk);
        measure(win);
        for (int n = 0; n < 8; n++)
            check(hi_cnt[n], pl[n] ? exp_hi(jp, n, win) : 16'(win) - exp_hi(jp, n, win));
    endtask
    // ----
    // Main sequence
    // ----
    initial
    begin
        reset_n = 1'b0;
        addr = 6'h0;
        wdata = 8'h0;
        wr = 1'b0;
        rd = 1'b0;
        clr = 1'b0;
        n_errors = 0;
        check_count = 0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        #1;
        rd_chk(`MPWM_OFS_PERIOD, `MPWM_RST_PERIOD);
        rd_chk(`MPWM_OFS_DUTY + 6'h07, `MPWM_RST_DUTY);
        rd_chk(`MPWM_OFS_POLARITY, `MPWM_RST_POLARITY);
        rd_chk(`MPWM_OFS_OUTPUT, 8'h00);
        reg_wr(6'h3f, 8'h5a);
        rd_chk(6'h3f, 8'h00);
        rd_chk(6'h0c, 8'h00);
        reg_wr(`MPWM_OFS_PRESCALE, 8'h00);
        for (int n = 0; n < 8; n++)
        begin
            reg_wr(`MPWM_OFS_PERIOD + 6'(n), 8'h08);
            reg_wr(`MPWM_OFS_DUTY + 6'(n), duty(n));
        end
        reg_wr(`MPWM_OFS_ENABLE, 8'hff);
        rd_chk(`MPWM_OFS_ENABLE, 8'hff);
        sweep(4'h0, 8'hff, 80);
        check(rises[1], 16'd10);
        reg_wr(`MPWM_OFS_POLARITY, 8'h0f);
        sweep(4'h0, 8'h0f, 80);
        reg_wr(`MPWM_OFS_POLARITY, 8'hff);
        reg_wr(`MPWM_OFS_CENTER, 8'hff);
        sweep(4'h0, 8'hff, 160);
        reg_wr(`MPWM_OFS_CENTER, 8'h00);
        // Mixed joining, then all four pairs
        for (int k = 0; k < 2; k++)
        begin
            j = k ? 4'hf : 4'h5;
            reg_wr(`MPWM_OFS_ENABLE, 8'h00);
            reg_wr(`MPWM_OFS_JOIN, {4'h0, j});
            rd_chk(`MPWM_OFS_JOIN, {4'h0, j});
            for (int p = 0; p < 4; p++)
                reg_wr(`MPWM_OFS_PERIOD + 6'(2 * p), j[p] ? 8'h00 : 8'h08);
            reg_wr(`MPWM_OFS_ENABLE, 8'hff);
            sweep(j, 8'hff, 80);
        end
        reg_wr(`MPWM_OFS_ENABLE, 8'h00);
        reg_wr(`MPWM_OFS_JOIN, 8'h00);
        for (int p = 0; p < 4; p++)
            reg_wr(`MPWM_OFS_PERIOD + 6'(2 * p), 8'h08);
        // New duty waits for the period end
        reg_wr(`MPWM_OFS_PERIOD, 8'hff);
        reg_wr(`MPWM_OFS_DUTY, 8'h00);
        reg_wr(`MPWM_OFS_ENABLE, 8'h01);
        repeat (10) @(posedge clk);
        reg_wr(`MPWM_OFS_DUTY, 8'hff);
        rd_chk(`MPWM_OFS_DUTY, 8'hff);
        measure(20);
        check(hi_cnt[0], 16'h0);
        measure(300);
        check({15'h0, hi_cnt[0] != 16'h0}, 16'h1);
        // Disabled pins idle at the inverse of polarity
        reg_wr(`MPWM_OFS_POLARITY, 8'h00);
        reg_wr(`MPWM_OFS_ENABLE, 8'h00);
        repeat (8) @(posedge clk);
        rd_chk(`MPWM_OFS_OUTPUT, 8'hff);
        rd_chk(`MPWM_OFS_COUNT, 8'h00);
        measure(20);
        check(hi_cnt[0], 16'd20);
        // Slow prescaled and scaled sources hold back the counters
        reg_wr(`MPWM_OFS_PERIOD, 8'h08);
        reg_wr(`MPWM_OFS_DUTY, 8'h04);
        reg_wr(`MPWM_OFS_SCALE_A, 8'h00);
        reg_wr(`MPWM_OFS_SCALE_B, 8'h00);
        for (int s = 0; s < 2; s++)
        begin
            reg_wr(`MPWM_OFS_PRESCALE, s ? 8'h00 : 8'h77);
            reg_wr(`MPWM_OFS_CLKSEL, s ? 8'hff : 8'h00);
            reg_wr(`MPWM_OFS_ENABLE, 8'h05);
            measure(160);
            check({15'h0, rises[0] <= 16'h1}, 16'h1);
            check({15'h0, rises[2] <= 16'h1}, 16'h1);
            reg_wr(`MPWM_OFS_ENABLE, 8'h00);
        end
        conclude();
    end
endmodule
